// *** hdl/slf_pkg.sv ***
// Package for the sensor output framing block: register map, reset values,
// control word layout, frame timing counts and the carrier types.
// Assumes a 200 MHz system clock and a slower pixel clock sampled by it.
package slf_pkg;

  // Clock and serial bit timing.
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned BIT_TIME_NS    = 10;
  localparam int unsigned BIT_CYCLES     = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Frame geometry counts: burst and overhead in pixel periods, frame height in rows.
  localparam int unsigned BURST_PIXELS   = 128;
  localparam int unsigned FOT_PIXELS     = 16;
  localparam logic [15:0] ROWS_RESET     = 16'h0800;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  IDX_ROWS       = 8'h01;
  localparam logic [7:0]  IDX_STATUS     = 8'h02;
  localparam logic [7:0]  IDX_TRAINING   = 8'h4e;
  localparam logic [7:0]  IDX_DISABLE    = 8'h50;
  localparam logic [7:0]  IDX_PIN1_SEL   = 8'h6c;
  localparam logic [7:0]  IDX_PIN2_SEL   = 8'h6d;

  // Register reset values.
  localparam logic [11:0] TRAINING_RESET = 12'h000;
  localparam logic [23:0] DISABLE_RESET  = 24'h000000;
  localparam logic [7:0]  PIN_SEL_RESET  = 8'h00;

  // Control word bit positions and the idle word.
  localparam int unsigned CW_PIXEL_VALID = 0;
  localparam int unsigned CW_LINE_VALID  = 1;
  localparam int unsigned CW_FRAME_VALID = 2;
  localparam int unsigned CW_SLOT_OVH    = 3;
  localparam int unsigned CW_ROW_OVH     = 4;
  localparam int unsigned CW_FRAME_OVH   = 5;
  localparam int unsigned CW_INTEG_ONE   = 6;
  localparam int unsigned CW_INTEG_TWO   = 7;
  localparam logic [11:0] CW_IDLE        = 12'h200;

  // Output channel modes: sixteen, eight, four or two channels.
  localparam logic [1:0]  MODE_16        = 2'h0;
  localparam logic [1:0]  MODE_8         = 2'h1;
  localparam logic [1:0]  MODE_4         = 2'h2;
  localparam logic [1:0]  MODE_2         = 2'h3;

  // Readout phases, one-hot.
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_FOT  = 4'b0010,
    PH_SLOT = 4'b0100,
    PH_DATA = 4'b1000
  } slf_phase_t;

  // Wishbone request as seen by the slave.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } slf_wb_req_t;

  // Complete state of the framer.
  typedef struct packed {
    logic [2:0]        lclk_sync;
    slf_phase_t        phase;
    logic [7:0]        pix_cnt;
    logic [2:0]        burst_cnt;
    logic [15:0]       row_cnt;
    logic [1:0]        mode;
    logic              wide;
    logic              start_pend;
    logic [15:0][11:0] data_word;
    logic [11:0]       ctrl_word;
    logic [15:0][11:0] data_shift;
    logic [11:0]       ctrl_shift;
    logic [3:0]        bit_idx;
    logic [1:0]        div_cnt;
    logic              ser_active;
    logic              pin_one;
    logic              pin_two;
    logic [11:0]       training;
    logic [23:0]       chan_disable;
    logic [7:0]        pin1_sel;
    logic [7:0]        pin2_sel;
    logic [15:0]       rows;
    logic              ack;
    logic [31:0]       rdata;
  } slf_state_t;

endpackage

// *** hdl/slf_framer.sv ***
// Output framing for the sensor's serial data interface: sixteen data lanes,
// one control lane carrying the status word, a serial clock and two test pins.
// Assumes a Wishbone classic master on CLK and a pixel clock from outside.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps

// Overview of operation
// - Two-channel mode sends eight 128-pixel bursts per row.
// - Two-channel mode uses sources one and nine; others may be disabled.
// - Rows per frame come from a register that resets to 2048.
// - All sixteen outputs are driven; unused ones repeat an active source.
// - Duplication pattern follows the mode: pairs, quads or halves.
// - Status goes out on the control lane as 10 or 12 bit words.
// - Bits 0, 1, 2 flag pixel, line and frame validity.
// - Bits 3, 4, 5 mark burst, row and frame overhead.
// - Bits 6 and 7 show integration of block one and two.
// - Bit 9 is one, bits 8, 10, 11 zero; idle word is 512.
// - Integration bits are forced low during frame overhead.
// - Each test pin mirrors a control bit chosen by its select register.
// - Valid flags stretch with the row time in reduced modes.
// - The training word fills the data lanes whenever no pixel is valid.
// - The training word is a 12-bit register, sent at pixel width.
// - The control lane always carries the status word, never training.
// - Words go out least significant bit first, bit 0 while clock high.
// - One pixel period of overhead separates consecutive bursts.
// - Twelve-bit pixels limit the block to four channels or fewer.
module slf_framer (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              PIXEL_CLK,
  input  wire logic              FRAME_START,
  input  wire logic [1:0]        CHANNEL_MODE,
  input  wire logic              PIXEL_12BIT,
  input  wire logic              INTEG_ONE,
  input  wire logic              INTEG_TWO,
  input  wire logic [15:0][11:0] PIXEL_IN,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [9:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic [31:0]            WB_DAT_O,
  output logic                   WB_ACK_O,
  output logic [15:0]            DATA_OUT,
  output logic                   CTRL_OUT,
  output logic                   SERIAL_OUTPUT_CLOCK,
  output logic [15:0][11:0]      DATA_WORD,
  output logic [11:0]            CTRL_WORD,
  output logic                   TEST_PIN_ONE,
  output logic                   TEST_PIN_TWO
);

  slf_pkg::slf_state_t  s_q;
  slf_pkg::slf_state_t  s_d;
  slf_pkg::slf_wb_req_t wb;

  // Source lane feeding an output lane in a given mode.
  function automatic logic [3:0] src_lane(input logic [3:0] out_lane, input logic [1:0] mode);
    case (mode)
      slf_pkg::MODE_16: src_lane = out_lane;
      slf_pkg::MODE_8:  src_lane = out_lane & 4'he;
      slf_pkg::MODE_4:  src_lane = out_lane & 4'hc;
      slf_pkg::MODE_2:  src_lane = out_lane & 4'h8;
      default:          src_lane = out_lane;
    endcase
  endfunction

  // Number of bursts per row, less one, for a mode.
  function automatic logic [2:0] last_burst(input logic [1:0] mode);
    case (mode)
      slf_pkg::MODE_16: last_burst = 3'h0;
      slf_pkg::MODE_8:  last_burst = 3'h1;
      slf_pkg::MODE_4:  last_burst = 3'h3;
      slf_pkg::MODE_2:  last_burst = 3'h7;
      default:          last_burst = 3'h0;
    endcase
  endfunction

  // Picks a control bit for a test pin; unknown selections give low.
  function automatic logic pin_pick(input logic [7:0] sel, input logic [11:0] cw);
    case (sel)
      8'h00:   pin_pick = cw[slf_pkg::CW_INTEG_ONE];
      8'h01:   pin_pick = cw[slf_pkg::CW_INTEG_TWO];
      8'h02:   pin_pick = cw[slf_pkg::CW_PIXEL_VALID];
      8'h03:   pin_pick = cw[slf_pkg::CW_LINE_VALID];
      8'h04:   pin_pick = cw[slf_pkg::CW_FRAME_VALID];
      default: pin_pick = 1'b0;
    endcase
  endfunction

  // Merges a write into a register under the byte lane enables.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    lane_merge = r;
  endfunction

  // Bundles the bus inputs.
  assign wb = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                sel: WB_SEL_I, dat: WB_DAT_I};

  // Next-state logic: pixel sequencer, word building, serialiser and registers.
  always_comb begin
    logic              pix_edge;
    logic [1:0]        eff_mode;
    logic [7:0]        idx;
    logic [11:0]       width_mask;
    logic [11:0]       train_w;
    logic [11:0]       cw;
    logic              in_fot;
    logic [3:0]        last_bit;
    logic [31:0]       merged;
    pix_edge   = 1'b0;
    eff_mode   = slf_pkg::MODE_16;
    idx        = 8'h00;
    width_mask = 12'h000;
    train_w    = 12'h000;
    cw         = slf_pkg::CW_IDLE;
    in_fot     = 1'b0;
    last_bit   = 4'h0;
    merged     = 32'h00000000;
    s_d        = s_q;

    // Pixel clock: two flops synchronise it, the third finds the rising edge.
    s_d.lclk_sync = {s_q.lclk_sync[1:0], PIXEL_CLK};
    pix_edge      = s_q.lclk_sync[1] & ~s_q.lclk_sync[2];

    // A frame request waits for the next pixel period.
    if (FRAME_START) begin
      s_d.start_pend = 1'b1;
    end

    // Twelve-bit pixels cap the lanes at four.
    eff_mode = CHANNEL_MODE;
    if (PIXEL_12BIT && (CHANNEL_MODE == slf_pkg::MODE_16 || CHANNEL_MODE == slf_pkg::MODE_8)) begin
      eff_mode = slf_pkg::MODE_4;
    end

    // Sequencer advances one step on every pixel period.
    if (pix_edge) begin
      case (s_q.phase)
        slf_pkg::PH_IDLE: begin
          if (s_q.start_pend || FRAME_START) begin
            s_d.start_pend = 1'b0;
            s_d.phase      = slf_pkg::PH_FOT;
            s_d.pix_cnt    = 8'h00;
            s_d.mode       = eff_mode;
            s_d.wide       = PIXEL_12BIT;
          end
        end
        slf_pkg::PH_FOT: begin
          if (s_q.pix_cnt == 8'(slf_pkg::FOT_PIXELS - 1)) begin
            s_d.phase     = slf_pkg::PH_SLOT;
            s_d.burst_cnt = 3'h0;
            s_d.row_cnt   = 16'h0000;
          end else begin
            s_d.pix_cnt = s_q.pix_cnt + 8'h01;
          end
        end
        slf_pkg::PH_SLOT: begin
          // The overhead gap lasts exactly one pixel period.
          s_d.phase   = slf_pkg::PH_DATA;
          s_d.pix_cnt = 8'h00;
        end
        slf_pkg::PH_DATA: begin
          if (s_q.pix_cnt == 8'(slf_pkg::BURST_PIXELS - 1)) begin
            // Bursts per row follow the mode, eight in two-lane mode.
            if (s_q.burst_cnt == last_burst(s_q.mode)) begin
              if (s_q.row_cnt + 16'h0001 >= s_q.rows) begin
                s_d.phase = slf_pkg::PH_IDLE;
              end else begin
                s_d.phase     = slf_pkg::PH_SLOT;
                s_d.burst_cnt = 3'h0;
                s_d.row_cnt   = s_q.row_cnt + 16'h0001;
              end
            end else begin
              s_d.phase     = slf_pkg::PH_SLOT;
              s_d.burst_cnt = s_q.burst_cnt + 3'h1;
            end
          end else begin
            s_d.pix_cnt = s_q.pix_cnt + 8'h01;
          end
        end
        default: begin
          s_d.phase = slf_pkg::PH_IDLE;
        end
      endcase
    end

    // Status word for the pixel period that starts now.
    in_fot = (s_d.phase == slf_pkg::PH_FOT);
    cw     = slf_pkg::CW_IDLE;
    cw[slf_pkg::CW_PIXEL_VALID] = (s_d.phase == slf_pkg::PH_DATA);
    // Line valid spans every burst and inner gap of a row.
    cw[slf_pkg::CW_LINE_VALID]  = (s_d.phase == slf_pkg::PH_DATA) ||
                                  (s_d.phase == slf_pkg::PH_SLOT && s_d.burst_cnt != 3'h0);
    cw[slf_pkg::CW_FRAME_VALID] = (s_d.phase == slf_pkg::PH_DATA) ||
                                  (s_d.phase == slf_pkg::PH_SLOT);
    cw[slf_pkg::CW_SLOT_OVH]    = (s_d.phase == slf_pkg::PH_SLOT);
    cw[slf_pkg::CW_ROW_OVH]     = (s_d.phase == slf_pkg::PH_SLOT && s_d.burst_cnt == 3'h0);
    cw[slf_pkg::CW_FRAME_OVH]   = in_fot;
    cw[slf_pkg::CW_INTEG_ONE]   = INTEG_ONE & ~in_fot;
    cw[slf_pkg::CW_INTEG_TWO]   = INTEG_TWO & ~in_fot;

    // Word width follows the pixel width of the running frame.
    width_mask = (s_d.phase == slf_pkg::PH_IDLE ? PIXEL_12BIT : s_d.wide) ? 12'hfff : 12'h3ff;
    train_w    = s_q.training & width_mask;

    if (pix_edge) begin
      s_d.ctrl_word  = cw;
      s_d.ctrl_shift = cw;
      for (int o = 0; o < 16; o++) begin
        if (s_d.phase == slf_pkg::PH_DATA) begin
          // Lanes without a source repeat the active one.
          s_d.data_word[o] = PIXEL_IN[src_lane(4'(o), s_d.mode)] & width_mask;
        end else begin
          s_d.data_word[o] = train_w;
        end
        s_d.data_shift[o] = s_d.data_word[o];
      end
      s_d.pin_one    = pin_pick(s_q.pin1_sel, cw);
      s_d.pin_two    = pin_pick(s_q.pin2_sel, cw);
      s_d.bit_idx    = 4'h0;
      s_d.div_cnt    = 2'h0;
      s_d.ser_active = 1'b1;
    end else if (s_q.ser_active) begin
      // Shifts out one bit every BIT_CYCLES clocks, low bit first.
      last_bit = (width_mask[11]) ? 4'hb : 4'h9;
      if (s_q.div_cnt == 2'(slf_pkg::BIT_CYCLES - 1)) begin
        s_d.div_cnt    = 2'h0;
        s_d.ctrl_shift = {1'b0, s_q.ctrl_shift[11:1]};
        for (int o = 0; o < 16; o++) begin
          s_d.data_shift[o] = {1'b0, s_q.data_shift[o][11:1]};
        end
        if (s_q.bit_idx == last_bit) begin
          s_d.ser_active = 1'b0;
        end else begin
          s_d.bit_idx = s_q.bit_idx + 4'h1;
        end
      end else begin
        s_d.div_cnt = s_q.div_cnt + 2'h1;
      end
    end

    // Bus slave: ack one cycle after the request, dropped the cycle after.
    idx   = wb.adr[9:2];
    s_d.ack = wb.cyc & wb.stb & ~s_q.ack;
    if (wb.cyc && wb.stb && !s_q.ack) begin
      case (idx)
        slf_pkg::IDX_ROWS:     s_d.rdata = {16'h0000, s_q.rows};
        slf_pkg::IDX_STATUS:   s_d.rdata = {s_q.row_cnt, 4'h0, s_q.phase, s_q.burst_cnt,
                                            s_q.wide, s_q.mode, s_q.start_pend, 1'b0};
        slf_pkg::IDX_TRAINING: s_d.rdata = {20'h00000, s_q.training};
        slf_pkg::IDX_DISABLE:  s_d.rdata = {8'h00, s_q.chan_disable};
        slf_pkg::IDX_PIN1_SEL: s_d.rdata = {24'h000000, s_q.pin1_sel};
        slf_pkg::IDX_PIN2_SEL: s_d.rdata = {24'h000000, s_q.pin2_sel};
        default:               s_d.rdata = 32'h00000000;
      endcase
      if (wb.we) begin
        case (idx)
          slf_pkg::IDX_ROWS: begin
            merged   = lane_merge({16'h0000, s_q.rows}, wb.dat, wb.sel);
            s_d.rows = merged[15:0];
          end
          slf_pkg::IDX_TRAINING: begin
            merged       = lane_merge({20'h00000, s_q.training}, wb.dat, wb.sel);
            s_d.training = merged[11:0];
          end
          slf_pkg::IDX_DISABLE: begin
            merged           = lane_merge({8'h00, s_q.chan_disable}, wb.dat, wb.sel);
            s_d.chan_disable = merged[23:0];
          end
          slf_pkg::IDX_PIN1_SEL: begin
            merged       = lane_merge({24'h000000, s_q.pin1_sel}, wb.dat, wb.sel);
            s_d.pin1_sel = merged[7:0];
          end
          slf_pkg::IDX_PIN2_SEL: begin
            merged       = lane_merge({24'h000000, s_q.pin2_sel}, wb.dat, wb.sel);
            s_d.pin2_sel = merged[7:0];
          end
          default: begin
            merged = 32'h00000000;
          end
        endcase
      end
    end
  end

  // State register with asynchronous reset to constants.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q              <= '0;
      s_q.phase        <= slf_pkg::PH_IDLE;
      s_q.ctrl_word    <= slf_pkg::CW_IDLE;
      s_q.ctrl_shift   <= slf_pkg::CW_IDLE;
      s_q.training     <= slf_pkg::TRAINING_RESET;
      s_q.chan_disable <= slf_pkg::DISABLE_RESET;
      s_q.pin1_sel     <= slf_pkg::PIN_SEL_RESET;
      s_q.pin2_sel     <= slf_pkg::PIN_SEL_RESET;
      s_q.rows         <= slf_pkg::ROWS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Serial lanes: a disabled lane is held low to save power.
  always_comb begin
    for (int o = 0; o < 16; o++) begin
      DATA_OUT[o] = s_q.ser_active & s_q.data_shift[o][0] & ~s_q.chan_disable[o];
    end
  end

  // Serial clock is high for even bits, so bit 0 goes out while it is high.
  assign SERIAL_OUTPUT_CLOCK = s_q.ser_active & ~s_q.bit_idx[0];
  assign CTRL_OUT            = s_q.ser_active & s_q.ctrl_shift[0];
  assign DATA_WORD           = s_q.data_word;
  assign CTRL_WORD           = s_q.ctrl_word;
  assign TEST_PIN_ONE        = s_q.pin_one;
  assign TEST_PIN_TWO        = s_q.pin_two;
  assign WB_ACK_O            = s_q.ack;
  assign WB_DAT_O            = s_q.rdata;

endmodule

// *** verification/slf_framer_props.sv ***
// Checker for the sensor output framer: status word, lane copies,
// serial bit order, burst length and bus answer timing.
// Assumes it is bound to the framer top and sees only its ports.
`timescale 1ns/100ps
module slf_framer_props (
  input wire logic              CLK,
  input wire logic              RST_N,
  input wire logic [1:0]        CHANNEL_MODE,
  input wire logic              PIXEL_12BIT,
  input wire logic              WB_CYC_I,
  input wire logic              WB_STB_I,
  input wire logic              WB_ACK_O,
  input wire logic              CTRL_OUT,
  input wire logic              SERIAL_OUTPUT_CLOCK,
  input wire logic [15:0][11:0] DATA_WORD,
  input wire logic [11:0]       CTRL_WORD
);
  logic [1:0] low_q;
  logic [8:0] bcnt_q;
  logic       step;
  logic       slot_q;
  logic [3:0] mask;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Source mask of the live mode; twelve-bit words allow four lanes at most.
  assign mask = 4'hf << ((PIXEL_12BIT && !CHANNEL_MODE[1]) ? slf_pkg::MODE_4 : CHANNEL_MODE);
  assign step = SERIAL_OUTPUT_CLOCK && (low_q == 2'h3);

  // True when every lane repeats the lane that the mask picks as its source.
  function automatic logic dup_ok(input logic [15:0][11:0] w, input logic [3:0] m);
    dup_ok = 1'b1;
    for (int o = 0; o < 16; o++) begin
      if (w[o] != w[4'(o) & m]) dup_ok = 1'b0;
    end
  endfunction

  // Counts low samples of the serial clock and valid words of a burst.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_q  <= 2'h0;
      bcnt_q <= 9'h000;
      slot_q <= 1'b0;
    end else begin
      if (step) slot_q <= CTRL_WORD[3];
      low_q <= SERIAL_OUTPUT_CLOCK ? 2'h0 : ((low_q == 2'h3) ? 2'h3 : low_q + 2'h1);
      if (step) bcnt_q <= CTRL_WORD[0] ? bcnt_q + 9'h001 : 9'h000;
    end
  end

  // A word starts when the serial clock rises after a quiet gap.
  sequence serial_start;
    !SERIAL_OUTPUT_CLOCK [*3] ##1 SERIAL_OUTPUT_CLOCK;
  endsequence
  sequence lsb_order;
    CTRL_OUT == CTRL_WORD[0] ##2 CTRL_OUT == CTRL_WORD[1] ##2 CTRL_OUT == CTRL_WORD[2];
  endsequence

  fixed_bits_a: assert property (CTRL_WORD[11:8] == 4'h2)
    else $error("control word fixed bits wrong");
  reset_idle_a: assert property ($rose(RST_N) |-> CTRL_WORD == slf_pkg::CW_IDLE)
    else $error("control word not idle after reset");
  fot_integ_a: assert property (CTRL_WORD[5] |-> CTRL_WORD[7:6] == 2'h0)
    else $error("integration bits high during frame overhead");
  valid_nest_a: assert property (CTRL_WORD[0] |-> CTRL_WORD[5:1] == 5'h03)
    else $error("pixel valid without line and frame valid");
  lane_copy_a: assert property (CTRL_WORD[0] |-> dup_ok(DATA_WORD, mask))
    else $error("lane copies do not follow the mode");
  train_fill_a: assert property (!CTRL_WORD[0] && CTRL_WORD[2] |-> dup_ok(DATA_WORD, 4'h0))
    else $error("lanes differ outside pixel data");
  lsb_first_a: assert property (serial_start |-> lsb_order)
    else $error("control lane bit order wrong");
  burst_len_a: assert property (step && !CTRL_WORD[0] && bcnt_q != 0 |-> bcnt_q == 9'h080)
    else $error("burst length not 128 words");
  slot_gap_a: assert property (step && slot_q |-> CTRL_WORD[0] && !CTRL_WORD[3])
    else $error("burst gap not one pixel period");
  ack_next_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered next cycle");
  ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("bus answer longer than one cycle");
endmodule

// *** verification/slf_rx_model.sv ***
// Receiver model for the framer's serial lanes: finds word starts from the
// serial clock, shifts in the control lane and one data lane, counts pixels.
// Assumes the width input matches the width the framer latched.
`timescale 1ns/100ps
module slf_rx_model (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  ctrl_in,
  input  wire logic  lane_in,
  input  wire logic  sclk,
  input  wire logic  wide,
  output logic        rx_stb,
  output logic [11:0] rx_ctrl,
  output logic [11:0] rx_data,
  output int          valid_cnt
);
  int          low_n;
  int          k;
  logic [11:0] sc;
  logic [11:0] sd;

  // Takes bit n at 2n cycles after the start, lowest bit first.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_n = 0;
      k = 99;
      rx_stb <= 1'b0;
      valid_cnt <= 0;
    end else begin
      rx_stb <= 1'b0;
      if (sclk && low_n >= 3) k = 0;
      if (k < 24 && k % 2 == 0) begin
        sc[k/2] = ctrl_in;
        sd[k/2] = lane_in;
        if (k / 2 == (wide ? 11 : 9)) begin
          rx_stb  <= 1'b1;
          rx_ctrl <= wide ? sc : {2'h0, sc[9:0]};
          rx_data <= wide ? sd : {2'h0, sd[9:0]};
          if (sc[2:0] == 3'h7) valid_cnt <= valid_cnt + 1;
        end
      end
      k = k + 1;
      low_n = sclk ? 0 : low_n + 1;
    end
  end
endmodule

// *** verification/slf_framer_tb_top.sv ***
// Testbench for the sensor output framer: register access, one frame per
// channel mode and twelve-bit mode, per-word checks against the receiver.
// Assumes the framer, its package, the receiver model and the checker.
`timescale 1ns/100ps
module slf_framer_tb_top;
  logic              CLK, RST_N, PIXEL_CLK, FRAME_START, PIXEL_12BIT, INTEG_ONE;
  logic              INTEG_TWO, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, CTRL_OUT;
  logic              SERIAL_OUTPUT_CLOCK, TEST_PIN_ONE, TEST_PIN_TWO, pclk_d, rx_stb;
  logic [1:0]        CHANNEL_MODE, integ_prev;
  logic [3:0]        WB_SEL_I, mask;
  logic [9:0]        WB_ADR_I;
  logic [31:0]       WB_DAT_I, WB_DAT_O, q;
  logic [15:0]       DATA_OUT;
  logic [11:0]       CTRL_WORD, rx_ctrl, rx_data, trn, wm;
  logic [15:0][11:0] PIXEL_IN, pix_prev, DATA_WORD;
  logic [7:0]        psel1, psel2;
  int                error_cnt, checks_done, seed, valid_cnt, n;

  slf_framer slf_framer_i (.CLK(CLK), .RST_N(RST_N), .PIXEL_CLK(PIXEL_CLK),
    .FRAME_START(FRAME_START), .CHANNEL_MODE(CHANNEL_MODE), .PIXEL_12BIT(PIXEL_12BIT),
    .INTEG_ONE(INTEG_ONE), .INTEG_TWO(INTEG_TWO), .PIXEL_IN(PIXEL_IN), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .DATA_OUT(DATA_OUT),
    .CTRL_OUT(CTRL_OUT), .SERIAL_OUTPUT_CLOCK(SERIAL_OUTPUT_CLOCK), .DATA_WORD(DATA_WORD),
    .CTRL_WORD(CTRL_WORD), .TEST_PIN_ONE(TEST_PIN_ONE), .TEST_PIN_TWO(TEST_PIN_TWO));
  slf_rx_model slf_rx_model_i (.clk(CLK), .rst_n(RST_N), .ctrl_in(CTRL_OUT),
    .lane_in(DATA_OUT[0]), .sclk(SERIAL_OUTPUT_CLOCK), .wide(PIXEL_12BIT), .rx_stb(rx_stb),
    .rx_ctrl(rx_ctrl), .rx_data(rx_data), .valid_cnt(valid_cnt));

  // System clock and a free pixel clock of unrelated phase.
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  initial begin
    PIXEL_CLK = 1'b0;
    #1.3;
    forever #62.5 PIXEL_CLK = ~PIXEL_CLK;
  end

  // Counts a comparison and reports a mismatch.
  task chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Test pin level expected for a select value and a status word.
  function automatic logic pin_exp(input logic [7:0] s, input logic [11:0] w);
    case (s)
      8'h00: pin_exp = w[6];
      8'h01: pin_exp = w[7];
      8'h02: pin_exp = w[0];
      8'h03: pin_exp = w[1];
      8'h04: pin_exp = w[2];
      default: pin_exp = 1'b0;
    endcase
  endfunction

  // One classic bus cycle; waits for the answer, the watchdog ends a hang.
  task wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= {idx, 2'h0};
    WB_DAT_I <= d;
    do begin
      @(posedge CLK);
    end while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK);
  endtask

  // Waits for frame valid to reach a level; a stuck flag shows as a mismatch.
  task wait_fv(input logic v);
    n = 0;
    while (CTRL_WORD[2] !== v && n < 40000) begin
      @(posedge CLK);
      n++;
    end
    chk({11'h0, CTRL_WORD[2]}, {11'h0, v});
  endtask

  // Runs one frame in a mode and checks the count of valid pixel words.
  task frame(input logic [1:0] m, input logic w, input logic [15:0] rows, input logic [7:0] s);
    int v0;
    CHANNEL_MODE <= m;
    PIXEL_12BIT  <= w;
    mask = 4'hf << ((w && !m[1]) ? slf_pkg::MODE_4 : m);
    wb(1'b1, slf_pkg::IDX_ROWS, {16'h0, rows});
    wb(1'b1, slf_pkg::IDX_PIN1_SEL, {24'h0, s});
    wb(1'b1, slf_pkg::IDX_PIN2_SEL, {24'h0, 8'h04 - s});
    psel1 = s;
    psel2 = 8'h04 - s;
    v0 = valid_cnt;
    FRAME_START <= 1'b1;
    @(posedge CLK);
    FRAME_START <= 1'b0;
    wait_fv(1'b1);
    wait_fv(1'b0);
    repeat (60) @(posedge CLK);
    chk(12'(valid_cnt - v0), 12'(rows * 128 * (16 >> $countones(mask))));
    $display("frame mode %0d wide %0d done", m, w);
  endtask

  // New pixel data and integration flags after each pixel clock fall.
  always @(posedge CLK) begin
    pclk_d <= PIXEL_CLK;
    if (pclk_d && !PIXEL_CLK) begin
      pix_prev <= PIXEL_IN;
      integ_prev <= {INTEG_TWO, INTEG_ONE};
      for (int i = 0; i < 16; i++) PIXEL_IN[i] <= 12'($random(seed));
      INTEG_ONE <= 1'($random(seed));
      INTEG_TWO <= 1'($random(seed));
    end
  end

  // Per-word checks once the receiver holds a whole word.
  always @(posedge CLK) begin
    if (rx_stb && (CTRL_WORD[2] || CTRL_WORD[5])) begin
      wm = PIXEL_12BIT ? 12'hfff : 12'h3ff;
      chk(rx_ctrl, CTRL_WORD & wm);
      chk(rx_data, DATA_WORD[0] & wm);
      chk({11'h0, TEST_PIN_ONE}, {11'h0, pin_exp(psel1, CTRL_WORD)});
      chk({11'h0, TEST_PIN_TWO}, {11'h0, pin_exp(psel2, CTRL_WORD)});
      chk({10'h0, CTRL_WORD[7:6]}, CTRL_WORD[5] ? 12'h000 : {10'h0, integ_prev});
      chk({11'h0, |DATA_OUT[14:1]}, 12'h000);
      if (CTRL_WORD[0]) chk(DATA_WORD[15] & wm, pix_prev[mask] & wm);
      else chk(DATA_WORD[15] & wm, trn & wm);
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Cuts a hang short after the span the frames should need.
  initial begin
    repeat (95000) @(posedge CLK);
    error_cnt++;
    test_done();
  end

  // Reset, register checks, then one frame per mode and select value.
  initial begin
    {error_cnt, checks_done, seed} = {32'd0, 32'd0, 32'd68797};
    {RST_N, FRAME_START, CHANNEL_MODE, PIXEL_12BIT, INTEG_ONE, INTEG_TWO} = '0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, PIXEL_IN, pix_prev} = '0;
    {WB_SEL_I, psel1, psel2, trn, mask} = {4'hf, 8'h00, 8'h00, 12'h000, 4'hf};
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    wb(1'b0, slf_pkg::IDX_ROWS, 32'h0);
    chk(q[11:0], slf_pkg::ROWS_RESET[11:0]);
    wb(1'b0, slf_pkg::IDX_TRAINING, 32'h0);
    chk(q[11:0], slf_pkg::TRAINING_RESET);
    wb(1'b0, slf_pkg::IDX_DISABLE, 32'h0);
    chk(q[11:0], slf_pkg::DISABLE_RESET[11:0]);
    wb(1'b0, 8'h10, 32'h0);
    chk(q[11:0], 12'h000);
    trn = 12'($random(seed));
    wb(1'b1, slf_pkg::IDX_TRAINING, {20'h0, trn});
    wb(1'b0, slf_pkg::IDX_TRAINING, 32'h0);
    chk(q[11:0], trn);
    wb(1'b1, slf_pkg::IDX_DISABLE, 32'h00007ffe);
    $display("register test done");
    for (int f = 0; f < 5; f++) frame((f < 4) ? 2'(f) : slf_pkg::MODE_16, f == 4, (f < 2) ? 16'h2 : 16'h1, 8'(f));
    wb(1'b0, slf_pkg::IDX_STATUS, 32'h0);
    chk({8'h0, q[11:8]}, 12'h001);
    test_done();
  end
endmodule

bind slf_framer slf_framer_props slf_framer_props_i (.CLK(CLK), .RST_N(RST_N),
  .CHANNEL_MODE(CHANNEL_MODE), .PIXEL_12BIT(PIXEL_12BIT), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .CTRL_OUT(CTRL_OUT),
  .SERIAL_OUTPUT_CLOCK(SERIAL_OUTPUT_CLOCK), .DATA_WORD(DATA_WORD), .CTRL_WORD(CTRL_WORD));
